// ### rph_ctrl.v
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "rph_defs.vh"

module rph_ctrl (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Demodulated bit stream and sync detector
  input  wire        rx_bit_valid,
  input  wire        rx_bit,
  input  wire        sync_det,
  // Received bytes and link metrics
  input  wire        rx_byte_valid,
  input  wire [7:0]  rx_byte,
  input  wire [7:0]  rssi,
  input  wire [6:0]  lqi,
  // Received packet output
  output reg         sync_accept,
  output reg         rx_out_valid,
  output reg  [7:0]  rx_out_byte,
  output reg         rx_done,
  output reg         rx_drop,
  output reg         rx_crc_ok,
  // Transmit byte stream
  input  wire        tx_in_valid,
  input  wire [7:0]  tx_in_byte,
  input  wire        tx_in_last,
  output reg         tx_out_valid,
  output reg  [7:0]  tx_out_byte,
  output reg         tx_busy
);

  localparam [4:0] RX_IDLE = 5'h01;
  localparam [4:0] RX_LEN  = 5'h02;
  localparam [4:0] RX_DATA = 5'h04;
  localparam [4:0] RX_CRC  = 5'h08;
  localparam [4:0] RX_STAT = 5'h10;

  // One CRC-16 byte step, MSB first
  function [15:0] crc_step;
    input [15:0] crc;
    input [7:0]  data;
    input [15:0] poly;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i])
          c = {c[14:0], 1'b0} ^ poly;
        else
          c = {c[14:0], 1'b0};
      end
      crc_step = c;
    end
  endfunction

  // Advance the PN9 sequence by eight bits
  function [8:0] pn9_adv8;
    input [8:0] s;
    integer i;
    reg [8:0] t;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1)
        t = {t[5] ^ t[0], t[8:1]};
      pn9_adv8 = t;
    end
  endfunction

  reg  [7:0]  plen_r;
  reg  [7:0]  ctla_r;
  reg  [7:0]  ctlb_r;
  reg  [7:0]  devaddr_r;
  reg  [7:0]  plen_nxt;
  reg  [7:0]  ctla_nxt;
  reg  [7:0]  ctlb_nxt;
  reg  [7:0]  devaddr_nxt;
  reg         wr_pend_r;
  reg  [15:0] widx_r;
  reg  [7:0]  rd_nxt;

  reg  [4:0]  rx_st_r;
  reg  [7:0]  rx_rem_r;
  reg         rx_first_r;
  reg         rx_sub_r;
  reg  [8:0]  rx_pn_r;
  reg  [15:0] rx_crc_r;

  reg  [1:0]  tx_pend_r;
  reg         tx_first_r;
  reg  [8:0]  tx_pn_r;
  reg  [15:0] tx_crc_r;

  wire        pq_gate;
  wire        sync_ok;

  // Configuration fields
  wire [2:0]  pq_thr   = ctla_r[`RPH_PQ_THR_HI:`RPH_PQ_THR_LO];
  wire        append   = ctla_r[`RPH_APPEND_BIT];
  wire [1:0]  adr_mode = ctla_r[`RPH_ADRCHK_HI:`RPH_ADRCHK_LO];
  wire        white_en = ctlb_r[`RPH_WHITE_BIT];
  wire [1:0]  fmt      = ctlb_r[`RPH_FMT_HI:`RPH_FMT_LO];
  wire        legacy   = ctlb_r[`RPH_LEGACY_BIT];
  wire        crc_en   = ctlb_r[`RPH_CRCEN_BIT];
  wire [1:0]  len_cfg  = ctlb_r[`RPH_LENCFG_HI:`RPH_LENCFG_LO];
  wire [15:0] poly     = legacy ? `RPH_CRC_POLY_OLD : `RPH_CRC_POLY;

  // Bus address phase decode
  wire        ap_valid = hsel && htrans[1] && hready;
  wire        ap_hit   = (haddr[31:18] == 14'h0000) && (haddr[1:0] == 2'b00)
                         && (hsize == 3'b010);
  wire [15:0] ap_idx   = haddr[17:2];

  // Write data lands in the data phase
  always @* begin
    plen_nxt    = plen_r;
    ctla_nxt    = ctla_r;
    ctlb_nxt    = ctlb_r;
    devaddr_nxt = devaddr_r;
    if (wr_pend_r) begin
      case (widx_r)
        `RPH_IDX_PLEN:   plen_nxt    = hwdata[7:0];
        `RPH_IDX_CTLA:   ctla_nxt    = hwdata[7:0] & `RPH_MASK_CTLA;
        `RPH_IDX_CTLB:   ctlb_nxt    = hwdata[7:0] & `RPH_MASK_CTLB;
        `RPH_IDX_ADDR:   devaddr_nxt = hwdata[7:0];
        default:         plen_nxt    = plen_r;
      endcase
    end
  end

  // Read mux sees a write finishing in the same cycle
  always @* begin
    case (ap_idx)
      `RPH_IDX_PLEN:   rd_nxt = plen_nxt;
      `RPH_IDX_CTLA:   rd_nxt = ctla_nxt;
      `RPH_IDX_CTLB:   rd_nxt = ctlb_nxt;
      `RPH_IDX_ADDR:   rd_nxt = devaddr_nxt;
      `RPH_IDX_STAT:   rd_nxt = {4'h0, pq_gate, rx_crc_ok, tx_busy, ~rx_st_r[0]};
      default:         rd_nxt = 8'h00;
    endcase
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      wr_pend_r <= 1'b0;
      widx_r    <= 16'h0000;
      plen_r    <= `RPH_RST_PLEN;
      ctla_r    <= `RPH_RST_CTLA;
      ctlb_r    <= `RPH_RST_CTLB;
      devaddr_r <= `RPH_RST_ADDR;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      plen_r    <= plen_nxt;
      ctla_r    <= ctla_nxt;
      ctlb_r    <= ctlb_nxt;
      devaddr_r <= devaddr_nxt;
      wr_pend_r <= ap_valid && hwrite && ap_hit;
      widx_r    <= ap_idx;
      if (ap_valid && !hwrite)
        hrdata <= ap_hit ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
    end
  end

  // Preamble quality estimator on the raw bit stream
  rph_pqe u_pqe (
    .clk       (hclk),
    .rst_n     (hresetn),
    .bit_valid (rx_bit_valid),
    .bit_in    (rx_bit),
    .clr       (sync_accept),
    .threshold (pq_thr),
    .gate      (pq_gate)
  );

  assign sync_ok = sync_det && pq_gate && rx_st_r[0];

  // Receive byte after de-whitening and its CRC update
  wire [7:0]  rx_d     = white_en ? (rx_byte ^ rx_pn_r[7:0]) : rx_byte;
  wire [15:0] rx_crc_w = crc_step(rx_crc_r, rx_d, poly);
  wire        adr_ok   = (rx_d == devaddr_r)
                         || (adr_mode[1] && (rx_d == `RPH_BCAST_LO))
                         || ((adr_mode == `RPH_ADR_BC0FF) && (rx_d == `RPH_BCAST_HI));
  wire        rx_last  = (rx_rem_r == 8'h01);

  // Receive sequencer; packet format is ignored so PN9 mode acts as normal
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_r      <= RX_IDLE;
      rx_rem_r     <= 8'h00;
      rx_first_r   <= 1'b0;
      rx_sub_r     <= 1'b0;
      rx_pn_r      <= `RPH_PN9_INIT;
      rx_crc_r     <= `RPH_CRC_INIT;
      sync_accept  <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_byte  <= 8'h00;
      rx_done      <= 1'b0;
      rx_drop      <= 1'b0;
      rx_crc_ok    <= 1'b0;
    end else begin
      sync_accept  <= sync_ok;
      rx_out_valid <= 1'b0;
      rx_done      <= 1'b0;
      rx_drop      <= 1'b0;
      if (rx_byte_valid && (rx_st_r[1] || rx_st_r[2] || rx_st_r[3])) begin
        rx_pn_r  <= pn9_adv8(rx_pn_r);
        rx_crc_r <= rx_crc_w;
      end
      case (rx_st_r)
        RX_IDLE: begin
          if (sync_ok) begin
            rx_pn_r    <= `RPH_PN9_INIT;
            rx_crc_r   <= `RPH_CRC_INIT;
            rx_rem_r   <= plen_r;
            rx_first_r <= 1'b1;
            rx_sub_r   <= 1'b0;
            rx_crc_ok  <= 1'b0;
            if (len_cfg == `RPH_LEN_VAR)
              rx_st_r <= RX_LEN;
            else
              rx_st_r <= RX_DATA;
          end
        end
        RX_LEN: begin
          if (rx_byte_valid) begin
            if ((rx_d == 8'h00) || (rx_d > plen_r)) begin
              rx_drop <= 1'b1;
              rx_st_r <= RX_IDLE;
            end else begin
              rx_rem_r     <= rx_d;
              rx_out_valid <= 1'b1;
              rx_out_byte  <= rx_d;
              rx_st_r      <= RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (rx_byte_valid) begin
            rx_first_r <= 1'b0;
            if (rx_first_r && (adr_mode != `RPH_ADR_NONE) && !adr_ok) begin
              rx_drop <= 1'b1;
              rx_st_r <= RX_IDLE;
            end else begin
              rx_out_valid <= 1'b1;
              rx_out_byte  <= rx_d;
              rx_rem_r     <= rx_rem_r - 8'h01;
              if (rx_last) begin
                if (crc_en)
                  rx_st_r <= RX_CRC;
                else if (append)
                  rx_st_r <= RX_STAT;
                else begin
                  rx_done <= 1'b1;
                  rx_st_r <= RX_IDLE;
                end
              end
            end
          end
        end
        RX_CRC: begin
          if (rx_byte_valid) begin
            rx_sub_r <= ~rx_sub_r;
            if (rx_sub_r) begin
              rx_crc_ok <= (rx_crc_w == 16'h0000);
              if (append)
                rx_st_r <= RX_STAT;
              else begin
                rx_done <= 1'b1;
                rx_st_r <= RX_IDLE;
              end
            end
          end
        end
        RX_STAT: begin
          rx_out_valid <= 1'b1;
          rx_sub_r     <= ~rx_sub_r;
          if (!rx_sub_r)
            rx_out_byte <= rssi;
          else begin
            rx_out_byte <= {rx_crc_ok, lqi};
            rx_done     <= 1'b1;
            rx_st_r     <= RX_IDLE;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  // Transmit side: frame start selects fresh seeds
  wire        tx_pn9   = (fmt == `RPH_FMT_PN9);
  wire [8:0]  tx_pn_c  = tx_first_r ? `RPH_PN9_INIT : tx_pn_r;
  wire [15:0] tx_crc_c = tx_first_r ? `RPH_CRC_INIT : tx_crc_r;
  wire [7:0]  tx_crc_b = tx_pend_r[1] ? tx_crc_r[15:8] : tx_crc_r[7:0];
  wire [7:0]  tx_white = white_en ? tx_pn_c[7:0] : 8'h00;

  // Transmit whitening, CRC append and PN9 test data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pend_r    <= 2'b00;
      tx_first_r   <= 1'b1;
      tx_pn_r      <= `RPH_PN9_INIT;
      tx_crc_r     <= `RPH_CRC_INIT;
      tx_out_valid <= 1'b0;
      tx_out_byte  <= 8'h00;
      tx_busy      <= 1'b0;
    end else begin
      tx_out_valid <= 1'b0;
      if (tx_pend_r != 2'b00) begin
        tx_out_valid <= 1'b1;
        tx_out_byte  <= tx_crc_b ^ tx_white;
        tx_pn_r      <= pn9_adv8(tx_pn_r);
        tx_pend_r    <= {1'b0, tx_pend_r[1]};
        tx_busy      <= tx_pend_r[1];
        if (tx_pend_r[0])
          tx_first_r <= 1'b1;
      end else if (tx_in_valid) begin
        tx_out_valid <= 1'b1;
        tx_pn_r      <= pn9_adv8(tx_pn_c);
        tx_crc_r     <= crc_step(tx_crc_c, tx_in_byte, poly);
        tx_first_r   <= tx_in_last;
        if (tx_pn9)
          tx_out_byte <= tx_pn_c[7:0];
        else
          tx_out_byte <= tx_in_byte ^ tx_white;
        if (tx_in_last && crc_en && !tx_pn9) begin
          tx_pend_r  <= 2'b10;
          tx_busy    <= 1'b1;
          tx_first_r <= 1'b0;
        end
      end
    end
  end

endmodule

// ### rph_defs.vh
`ifndef RPH_DEFS_VH
`define RPH_DEFS_VH

// Register indices; byte address is four times the index
`define RPH_IDX_PLEN     16'hdf02
`define RPH_IDX_CTLA     16'hdf03
`define RPH_IDX_CTLB     16'hdf04
`define RPH_IDX_ADDR     16'hdf05
`define RPH_IDX_STAT     16'hdf3e

// Reset values
`define RPH_RST_PLEN     8'hff
`define RPH_RST_CTLA     8'h04
`define RPH_RST_CTLB     8'h45
`define RPH_RST_ADDR     8'h00

// Writable bit masks, unused bits read as zero
`define RPH_MASK_CTLA    8'he7
`define RPH_MASK_CTLB    8'h7f

// Field positions in control register a
`define RPH_PQ_THR_HI    7
`define RPH_PQ_THR_LO    5
`define RPH_APPEND_BIT   2
`define RPH_ADRCHK_HI    1
`define RPH_ADRCHK_LO    0

// Field positions in control register b
`define RPH_WHITE_BIT    6
`define RPH_FMT_HI       5
`define RPH_FMT_LO       4
`define RPH_LEGACY_BIT   3
`define RPH_CRCEN_BIT    2
`define RPH_LENCFG_HI    1
`define RPH_LENCFG_LO    0

// Encodings
`define RPH_FMT_PN9      2'b10
`define RPH_LEN_FIXED    2'b00
`define RPH_LEN_VAR      2'b01
`define RPH_ADR_NONE     2'b00
`define RPH_ADR_BC0      2'b10
`define RPH_ADR_BC0FF    2'b11
`define RPH_BCAST_LO     8'h00
`define RPH_BCAST_HI     8'hff

// Preamble quality counter steps
`define RPH_PQ_INC       5'h01
`define RPH_PQ_DEC       5'h08
`define RPH_PQ_MAX       5'h1f

// CRC and whitening seeds and polynomials
`define RPH_CRC_INIT     16'hffff
`define RPH_CRC_POLY     16'h8005
`define RPH_CRC_POLY_OLD 16'h1021
`define RPH_PN9_INIT     9'h1ff

`endif

// ### rph_pqe.v
`timescale 1ns/10ps
`include "rph_defs.vh"

module rph_pqe (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Received bit stream
  input  wire       bit_valid,
  input  wire       bit_in,
  input  wire       clr,
  // Threshold and gate
  input  wire [2:0] threshold,
  output wire       gate
);

  reg [4:0] cnt_r;
  reg       prev_r;
  reg       have_prev_r;

  // Zero threshold always passes, else count must reach four times it
  assign gate = (threshold == 3'h0) || (cnt_r >= {threshold, 2'b00});

  // Quality counter: up on transition, down on repeat
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= 5'h00;
      prev_r      <= 1'b0;
      have_prev_r <= 1'b0;
    end else if (clr) begin
      cnt_r       <= 5'h00;
      have_prev_r <= 1'b0;
    end else if (bit_valid) begin
      prev_r      <= bit_in;
      have_prev_r <= 1'b1;
      if (have_prev_r && (bit_in != prev_r)) begin
        if (cnt_r != `RPH_PQ_MAX)
          cnt_r <= cnt_r + `RPH_PQ_INC;
      end else if (have_prev_r) begin
        if (cnt_r > `RPH_PQ_DEC)
          cnt_r <= cnt_r - `RPH_PQ_DEC;
        else
          cnt_r <= 5'h00;
      end
    end
  end

endmodule

// ### rph_ctrl_sva.sv
`timescale 1ns/10ps
module rph_ctrl_chk (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Receive side
  input wire sync_det,
  input wire sync_accept,
  input wire rx_out_valid,
  input wire rx_done,
  input wire rx_drop,
  input wire rx_crc_ok,
  // Transmit side
  input wire tx_in_valid,
  input wire tx_out_valid,
  input wire tx_busy
);
  // One domain, quiet in reset
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Data byte, then CRC high while still busy, then CRC low with busy gone
  sequence crc_tail_s;
    tx_out_valid ##1 (tx_out_valid && tx_busy) ##1 (tx_out_valid && !tx_busy);
  endsequence
  gate_pass_a: assert property (sync_accept |-> $past(sync_det))
    else $error("accept without sync");
  tx_pass_a: assert property (tx_in_valid && !tx_busy |=> tx_out_valid)
    else $error("tx byte lost");
  crc_tail_a: assert property ($rose(tx_busy) |-> crc_tail_s)
    else $error("crc tail wrong");
  busy_len_a: assert property ($rose(tx_busy) |=> tx_busy ##1 !tx_busy)
    else $error("busy too long");
  busy_out_a: assert property (tx_busy |-> tx_out_valid)
    else $error("busy without data");
  done_drop_a: assert property (!(rx_done && rx_drop))
    else $error("done and drop");
  drop_quiet_a: assert property (rx_drop |=> !rx_out_valid && !rx_done)
    else $error("output after drop");
  crc_clear_a: assert property (sync_accept |=> !rx_crc_ok)
    else $error("crc flag kept");
endmodule

bind rph_ctrl rph_ctrl_chk u_chk (
  .hclk, .hresetn, .sync_det, .sync_accept, .rx_out_valid, .rx_done,
  .rx_drop, .rx_crc_ok, .tx_in_valid, .tx_out_valid, .tx_busy
);

// ### rph_air.sv
`timescale 1ns/10ps
module rph_air (
  // Clock
  input  wire       hclk,
  // Bits and sync
  output reg        rx_bit_valid = 1'b0,
  output reg        rx_bit = 1'b0,
  output reg        sync_det = 1'b0,
  // Bytes and link metrics
  output reg        rx_byte_valid = 1'b0,
  output reg  [7:0] rx_byte = 8'h00,
  output reg  [7:0] rssi = 8'h5c,
  output reg  [6:0] lqi = 7'h2b
);
  // Preamble bits, lsb first; line flips once released
  task bits(input [7:0] p, input integer n);
    integer i;
    begin
      for (i = 0; i < n; i++) begin
        @(posedge hclk);
        rx_bit_valid <= 1'b1;
        rx_bit <= p[i];
      end
      @(posedge hclk);
      rx_bit_valid <= 1'b0;
      rx_bit <= ~rx_bit;
    end
  endtask
  // One-cycle sync pulse
  task send_sync;
    begin
      @(posedge hclk);
      sync_det <= 1'b1;
      @(posedge hclk);
      sync_det <= 1'b0;
    end
  endtask
  // One byte; released data shows its inverse
  task put(input [7:0] b);
    begin
      @(posedge hclk);
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      @(posedge hclk);
      rx_byte_valid <= 1'b0;
      rx_byte <= ~b;
    end
  endtask
endmodule

// ### radio_packet_handling_control_test.sv
`timescale 1ns/10ps
`include "rph_defs.vh"
module radio_packet_handling_control_test;
  // Bus side
  reg          hclk, hresetn, hsel, hwrite;
  reg  [31:0]  haddr, hwdata;
  reg  [1:0]   htrans;
  reg  [2:0]   hsize;
  wire         hready, hresp;
  wire [31:0]  hrdata;
  // Air and packet ports
  wire         rx_bit_valid, rx_bit, sync_det, rx_byte_valid;
  wire [7:0]   rx_byte, rssi, rx_out_byte, tx_out_byte;
  wire [6:0]   lqi;
  wire         sync_accept, rx_out_valid, rx_done, rx_drop, rx_crc_ok;
  wire         tx_out_valid, tx_busy;
  reg          tx_in_valid, tx_in_last;
  reg  [7:0]   tx_in_byte;
  // Bench state
  logic [7:0]  q[$], tq[$];
  logic        acc_f, done_f, drop_f;
  logic [31:0] v;
  integer      err_total, cmp_count;

  rph_ctrl u_rph_ctrl (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout(hready), .hresp, .rx_bit_valid, .rx_bit, .sync_det,
    .rx_byte_valid, .rx_byte, .rssi, .lqi, .sync_accept, .rx_out_valid,
    .rx_out_byte, .rx_done, .rx_drop, .rx_crc_ok, .tx_in_valid, .tx_in_byte,
    .tx_in_last, .tx_out_valid, .tx_out_byte, .tx_busy
  );
  rph_air u_rph_air (
    .hclk, .rx_bit_valid, .rx_bit, .sync_det, .rx_byte_valid, .rx_byte, .rssi, .lqi
  );

  // 40 MHz clock
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Output monitor
  always @(posedge hclk) begin
    if (rx_out_valid) q.push_back(rx_out_byte);
    if (tx_out_valid) tq.push_back(tx_out_byte);
    if (sync_accept) acc_f = 1'b1;
    if (rx_done) done_f = 1'b1;
    if (rx_drop) drop_f = 1'b1;
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    begin
      cmp_count++;
      if (g !== e) begin
        err_total++;
        $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask

  // Running CRC of one byte, msb first
  function [15:0] cf(input [15:0] c, input [7:0] d, input [15:0] p);
    integer i;
    begin
      cf = c;
      for (i = 7; i >= 0; i--) cf = (cf[15] ^ d[i]) ? (cf << 1) ^ p : cf << 1;
    end
  endfunction

  // Single AHB word transfer, held until hready
  task bus(input w, input [15:0] i, input [7:0] d, output [31:0] r);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {14'h0, i, 2'h0};
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      r = hrdata;
      hsel <= 1'b0;
    end
  endtask
  task wr(input [15:0] i, input [7:0] d);
    bus(1'b1, i, d, v);
  endtask
  task rdc(input [15:0] i, input [7:0] e);
    begin
      bus(1'b0, i, 8'h00, v);
      // An error response flips the top bit and so fails the compare
      chk(v ^ {hresp, 31'h0}, {24'h0, e});
    end
  endtask

  // Sync, n bytes from the top of d, wait for end
  task rxp(input integer n, input [39:0] d);
    integer k;
    begin
      q.delete();
      acc_f = 1'b0;
      done_f = 1'b0;
      drop_f = 1'b0;
      u_rph_air.send_sync;
      for (k = 0; k < n; k++) u_rph_air.put(d[39-8*k -: 8]);
      for (k = 0; k < 40 && !(done_f | drop_f); k++) @(posedge hclk);
    end
  endtask

  task t_regs;
    begin
      rdc(`RPH_IDX_PLEN, 8'hff);
      rdc(`RPH_IDX_CTLA, 8'h04);
      rdc(`RPH_IDX_CTLB, 8'h45);
      rdc(`RPH_IDX_ADDR, 8'h00);
      wr(`RPH_IDX_CTLA, 8'hff);
      rdc(`RPH_IDX_CTLA, 8'he7);
      wr(16'hdf06, 8'hff);
      rdc(16'hdf06, 8'h00);
    end
  endtask

  task t_gate;
    begin
      wr(`RPH_IDX_CTLB, 8'h01);
      wr(`RPH_IDX_CTLA, 8'h24);
      u_rph_air.bits(8'h2a, 6);
      rxp(2, 40'h01_3300_0000);
      chk(acc_f, 1'b1);
      chk(q.size(), 4);
      chk(q[1], 8'h33);
      chk(q[2], 8'h5c);
      chk(q[3], 8'h2b);
      u_rph_air.bits(8'hea, 8);
      rxp(0, 40'h0);
      chk(acc_f, 1'b0);
      wr(`RPH_IDX_CTLA, 8'h04);
      rxp(2, 40'h01_3300_0000);
      chk(acc_f, 1'b1);
    end
  endtask

  // Every filter mode against own, both broadcast and a foreign address
  task t_addr;
    integer m, a;
    reg [7:0] x;
    reg ok;
    begin
      wr(`RPH_IDX_ADDR, 8'h3c);
      for (m = 0; m < 4; m++) begin
        for (a = 0; a < 4; a++) begin
          x = a == 0 ? 8'h3c : a == 1 ? 8'h00 : a == 2 ? 8'hff : 8'h3d;
          ok = m == 0 || a == 0 || (m >= 2 && a == 1) || (m == 3 && a == 2);
          wr(`RPH_IDX_CTLA, {6'h01, m[1:0]});
          rxp(3, {8'h02, x, 24'h11_0000});
          chk(drop_f, !ok);
          chk(done_f, ok);
        end
      end
    end
  endtask

  task t_len;
    begin
      wr(`RPH_IDX_PLEN, 8'h02);
      rxp(1, 40'h03_0000_0000);
      chk(drop_f, 1'b1);
      rxp(3, 40'h02_3c11_0000);
      chk(done_f, 1'b1);
      wr(`RPH_IDX_CTLB, 8'h00);
      rxp(2, 40'h3c_7700_0000);
      chk(q.size(), 4);
      chk(q[1], 8'h77);
    end
  endtask

  // Standard then legacy CRC, whitening off for both
  task t_crc;
    integer j;
    reg [15:0] c, p;
    begin
      for (j = 0; j < 2; j++) begin
        wr(`RPH_IDX_CTLB, j ? 8'h0d : 8'h05);
        p = j ? `RPH_CRC_POLY_OLD : `RPH_CRC_POLY;
        c = cf(cf(16'hffff, 8'h01, p), 8'h3c, p);
        rxp(4, {16'h013c, c, 8'h00});
        chk(rx_crc_ok, 1'b1);
        rdc(`RPH_IDX_STAT, 8'h0c);
        chk(q[3], 8'hab);
        rxp(4, {16'h013c, ~c, 8'h00});
        chk(rx_crc_ok, 1'b0);
      end
    end
  endtask

  // One-byte frames: CRC, legacy CRC, whitening, PN9, plain
  task t_tx;
    integer j;
    reg [7:0] cb;
    reg [15:0] c;
    begin
      for (j = 0; j < 5; j++) begin
        cb = j == 0 ? 8'h05 : j == 1 ? 8'h0d : j == 2 ? 8'h41 : j == 3 ? 8'h21 : 8'h01;
        wr(`RPH_IDX_CTLB, cb);
        c = cf(16'hffff, 8'h5a, cb[3] ? `RPH_CRC_POLY_OLD : `RPH_CRC_POLY);
        tq.delete();
        @(posedge hclk);
        tx_in_valid <= 1'b1;
        tx_in_byte <= 8'h5a;
        @(posedge hclk);
        tx_in_valid <= 1'b0;
        tx_in_byte <= 8'ha5;
        repeat (5) @(posedge hclk);
        chk(tq.size(), cb[2] ? 3 : 1);
        chk(tq[0], j == 2 ? 8'ha5 : j == 3 ? 8'hff : 8'h5a);
        if (cb[2]) chk({tq[1], tq[2]}, c);
      end
    end
  endtask

  task summarize;
    begin
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {tx_in_valid, tx_in_last, tx_in_byte} = '0;
    {acc_f, done_f, drop_f} = '0;
    err_total = 0;
    cmp_count = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    tx_in_last <= 1'b1;
    t_regs;
    t_gate;
    t_addr;
    t_len;
    t_crc;
    t_tx;
    summarize;
  end

  // Watchdog
  initial begin
    #500000;
    err_total++;
    summarize;
  end
endmodule
